// ---- src/slc_pkg.sv ----
// Constants and types shared by the transmit link configuration register bank
package slc_pkg;

	// Register indices; the byte address on the bus is four times the index
	localparam logic [9:0] SLC_IDX_LINK_ENABLE = 10'h200;
	localparam logic [9:0] SLC_IDX_SW_SYNC = 10'h203;
	localparam logic [9:0] SLC_IDX_LINK_CONTROL = 10'h204;
	localparam logic [9:0] SLC_IDX_TEST_CONTROL = 10'h205;
	localparam logic [9:0] SLC_IDX_DEVICE_IDENT = 10'h206;
	localparam logic [9:0] SLC_IDX_FRAME_END_CHAR = 10'h207;
	localparam logic [9:0] SLC_IDX_CFG_STATUS = 10'h2F0;

	// Reset values
	localparam logic SLC_RST_LINK_ENABLE = 1'b1;
	localparam logic SLC_RST_SW_SYNC_N = 1'b1;
	localparam logic [7:0] SLC_RST_LINK_CONTROL = 8'h03;
	localparam logic [7:0] SLC_RST_TEST_CONTROL = 8'h00;
	localparam logic [7:0] SLC_RST_DEVICE_IDENT = 8'h00;
	localparam logic [7:0] SLC_RST_FRAME_END_CHAR = 8'h00;

	// Field positions in link_control
	localparam int SLC_POS_SCRAMBLER_ENABLE = 0;
	localparam int SLC_POS_SAMPLE_FORMAT = 1;
	localparam int SLC_POS_SYNC_SEL_LO = 2;
	localparam int SLC_POS_UPPER_LANES = 4;

	// Sync source selections
	localparam logic [1:0] SLC_SYNC_DEDICATED = 2'h0;
	localparam logic [1:0] SLC_SYNC_TIMESTAMP = 2'h1;
	localparam logic [1:0] SLC_SYNC_SOFTWARE = 2'h2;

	// Lane enable patterns per link
	localparam logic [7:0] SLC_LANES_LOWER = 8'h0F;
	localparam logic [7:0] SLC_LANES_UPPER = 8'hF0;
	localparam logic [7:0] SLC_LANES_OFF = 8'h00;

	// Test pattern codes
	typedef enum logic [4:0] {
		SLC_PAT_NORMAL = 5'h00,
		SLC_PAT_PRBS7 = 5'h01,
		SLC_PAT_PRBS15 = 5'h02,
		SLC_PAT_PRBS23 = 5'h03,
		SLC_PAT_RAMP = 5'h04,
		SLC_PAT_TRANSPORT = 5'h05,
		SLC_PAT_D21_5 = 5'h06,
		SLC_PAT_K28_5 = 5'h07,
		SLC_PAT_REPEAT_ILAS = 5'h08,
		SLC_PAT_MOD_RPAT = 5'h09,
		SLC_PAT_HOLD_LOW = 5'h0A,
		SLC_PAT_HOLD_HIGH = 5'h0B,
		SLC_PAT_PRBS9 = 5'h0D,
		SLC_PAT_PRBS31 = 5'h0E,
		SLC_PAT_CLOCK = 5'h0F,
		SLC_PAT_K28_7 = 5'h10
	} slc_pattern_type;

	// End-of-frame comma selections and their 8-bit control codes
	localparam logic [1:0] SLC_EOF_K28_7 = 2'h0;
	localparam logic [1:0] SLC_EOF_K28_1 = 2'h1;
	localparam logic [1:0] SLC_EOF_K28_5 = 2'h2;
	localparam logic [7:0] SLC_CHAR_K28_7 = 8'hFC;
	localparam logic [7:0] SLC_CHAR_K28_1 = 8'h3C;
	localparam logic [7:0] SLC_CHAR_K28_5 = 8'hBC;

endpackage

// ---- src/slc_tx_config_regs.sv ----
// Transmit link configuration registers behind a classic Wishbone slave
// How it works
// - Mapping clear: lower four lanes per link
// - Mapping set: upper four lanes per link
// - Sync source: dedicated pin, timestamp, or software only
// - Sample format bit picks offset/two's, resets one
// - Scrambler bit controls 8b/10b scrambling, resets one
// - 64b/66b always scrambles, ignoring the bit
// - Test field: normal, PRBS codes, reserved codes
// - Test field: ramp, transport, D21.5, hold, clock
// - K28.5, ILAS, RPAT, K28.7 tests need 8b/10b
// - Link A sends identifier, link B identifier+1
// - Identifier bit zero ignored, reads zero
// - End-of-frame field picks K28.7, K28.1, K28.5
// - Link disabled: hold reset, power down, gate clocks
// - Software sync bit low raises sync request
`timescale 1ns/1ps
`default_nettype none

module slc_tx_config_regs
	import slc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic dedicatedSyncInN,
	input wire logic timestampInN,
	input wire logic timestampReceiverEnable,
	input wire logic linkMode8b10b,
	output logic [7:0] laneEnableA,
	output logic [7:0] laneEnableB,
	output logic linkResetHold,
	output logic serializerPowerDown,
	output logic linkClockEnable,
	output logic syncRequest,
	output logic sampleTwosComplement,
	output logic scrambleActive,
	output logic [4:0] testPatternSelect,
	output logic testPatternRejected,
	output logic [7:0] ilasDeviceIdentA,
	output logic [7:0] ilasDeviceIdentB,
	output logic [7:0] endOfFrameComma
);

	typedef struct packed {
		logic linkEnable;
		logic swSyncN;
		logic [7:0] linkControl;
		logic [7:0] testControl;
		logic [7:0] deviceIdent;
		logic [7:0] frameEndChar;
		logic [2:0] syncPinSr;
		logic [2:0] tsPinSr;
		logic syncPinLevel;
		logic tsPinLevel;
		logic ack;
		logic [31:0] readData;
		logic [7:0] laneA;
		logic [7:0] laneB;
		logic linkHold;
		logic syncReq;
		logic twosComp;
		logic scramble;
		logic [4:0] pattern;
		logic patternBad;
		logic [7:0] identA;
		logic [7:0] identB;
		logic [7:0] eofChar;
	} slc_state_type;

	localparam slc_state_type SLC_RST_STATE = '{
		linkEnable: SLC_RST_LINK_ENABLE,
		swSyncN: SLC_RST_SW_SYNC_N,
		linkControl: SLC_RST_LINK_CONTROL,
		testControl: SLC_RST_TEST_CONTROL,
		deviceIdent: SLC_RST_DEVICE_IDENT,
		frameEndChar: SLC_RST_FRAME_END_CHAR,
		syncPinSr: 3'h7,
		tsPinSr: 3'h7,
		syncPinLevel: 1'b1,
		tsPinLevel: 1'b1,
		ack: 1'b0,
		readData: 32'h0000_0000,
		laneA: SLC_LANES_OFF,
		laneB: SLC_LANES_OFF,
		linkHold: 1'b1,
		syncReq: 1'b0,
		twosComp: 1'b1,
		scramble: 1'b1,
		pattern: SLC_PAT_NORMAL,
		patternBad: 1'b0,
		identA: 8'h00,
		identB: 8'h01,
		eofChar: SLC_CHAR_K28_7
	};

	slc_state_type state_ff;
	slc_state_type nxt_state;

	// Unsupported or reserved codes fall back to normal data rather than an undefined pattern
	function automatic logic [4:0] slcPatternEffective(input logic [4:0] code, input logic mode8b10b);
		case (code)
			SLC_PAT_NORMAL, SLC_PAT_PRBS7, SLC_PAT_PRBS15, SLC_PAT_PRBS23, SLC_PAT_PRBS9, SLC_PAT_PRBS31: begin
				return code;
			end
			SLC_PAT_RAMP, SLC_PAT_TRANSPORT, SLC_PAT_D21_5, SLC_PAT_HOLD_LOW, SLC_PAT_HOLD_HIGH, SLC_PAT_CLOCK: begin
				return code;
			end
			SLC_PAT_K28_5, SLC_PAT_REPEAT_ILAS, SLC_PAT_MOD_RPAT, SLC_PAT_K28_7: begin
				return mode8b10b ? code : SLC_PAT_NORMAL;
			end
			default: begin
				return SLC_PAT_NORMAL;
			end
		endcase
	endfunction

	// Reserved selection falls back to the default comma
	function automatic logic [7:0] slcCommaChar(input logic [1:0] sel);
		case (sel)
			SLC_EOF_K28_1: begin
				return SLC_CHAR_K28_1;
			end
			SLC_EOF_K28_5: begin
				return SLC_CHAR_K28_5;
			end
			default: begin
				return SLC_CHAR_K28_7;
			end
		endcase
	endfunction

	logic [9:0] busIndex;
	logic busWrite;
	logic [1:0] syncSel;
	logic [7:0] evenIdent;

	assign busIndex = wb_adr_i[11:2];
	// Writes land on the edge where the master sees ack; a request held past ack is acked and applied again every second cycle
	assign busWrite = state_ff.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
	assign syncSel = state_ff.linkControl[SLC_POS_SYNC_SEL_LO +: 2];
	assign evenIdent = {state_ff.deviceIdent[7:1], 1'b0};

	always_comb begin
		nxt_state = state_ff;

		// Three-stage pin sampling; only the second and third stages are compared
		nxt_state.syncPinSr = {state_ff.syncPinSr[1:0], dedicatedSyncInN};
		nxt_state.tsPinSr = {state_ff.tsPinSr[1:0], timestampInN};
		if (state_ff.syncPinSr[1] == state_ff.syncPinSr[2]) begin
			nxt_state.syncPinLevel = state_ff.syncPinSr[2];
		end
		if (state_ff.tsPinSr[1] == state_ff.tsPinSr[2]) begin
			nxt_state.tsPinLevel = state_ff.tsPinSr[2];
		end

		// One-cycle ack; unmapped addresses still answer with zero data
		nxt_state.ack = wb_cyc_i && wb_stb_i && !state_ff.ack;
		nxt_state.readData = 32'h0000_0000;
		if (wb_cyc_i && wb_stb_i && !state_ff.ack && !wb_we_i) begin
			case (busIndex)
				SLC_IDX_LINK_ENABLE: begin
					nxt_state.readData = {31'h0000_0000, state_ff.linkEnable};
				end
				SLC_IDX_SW_SYNC: begin
					nxt_state.readData = {31'h0000_0000, state_ff.swSyncN};
				end
				SLC_IDX_LINK_CONTROL: begin
					nxt_state.readData = {24'h00_0000, state_ff.linkControl};
				end
				SLC_IDX_TEST_CONTROL: begin
					nxt_state.readData = {24'h00_0000, state_ff.testControl};
				end
				SLC_IDX_DEVICE_IDENT: begin
					nxt_state.readData = {24'h00_0000, evenIdent};
				end
				SLC_IDX_FRAME_END_CHAR: begin
					nxt_state.readData = {24'h00_0000, state_ff.frameEndChar};
				end
				SLC_IDX_CFG_STATUS: begin
					nxt_state.readData = {29'h0000_0000, state_ff.patternBad, state_ff.scramble, state_ff.syncReq};
				end
				default: begin
					nxt_state.readData = 32'h0000_0000;
				end
			endcase
		end

		if (busWrite) begin
			case (busIndex)
				SLC_IDX_LINK_ENABLE: begin
					nxt_state.linkEnable = wb_dat_i[0];
				end
				SLC_IDX_SW_SYNC: begin
					nxt_state.swSyncN = wb_dat_i[0];
				end
				SLC_IDX_LINK_CONTROL: begin
					nxt_state.linkControl = wb_dat_i[7:0];
				end
				SLC_IDX_TEST_CONTROL: begin
					nxt_state.testControl = wb_dat_i[7:0];
				end
				SLC_IDX_DEVICE_IDENT: begin
					nxt_state.deviceIdent = {wb_dat_i[7:1], 1'b0};
				end
				SLC_IDX_FRAME_END_CHAR: begin
					nxt_state.frameEndChar = wb_dat_i[7:0];
				end
				default: begin
					nxt_state.linkEnable = state_ff.linkEnable;
				end
			endcase
		end

		// Link outputs; settings take effect whenever written, software is expected to disable first
		nxt_state.linkHold = !state_ff.linkEnable;
		if (!state_ff.linkEnable) begin
			nxt_state.laneA = SLC_LANES_OFF;
			nxt_state.laneB = SLC_LANES_OFF;
		end else if (state_ff.linkControl[SLC_POS_UPPER_LANES]) begin
			nxt_state.laneA = SLC_LANES_UPPER;
			nxt_state.laneB = SLC_LANES_UPPER;
		end else begin
			nxt_state.laneA = SLC_LANES_LOWER;
			nxt_state.laneB = SLC_LANES_LOWER;
		end

		// Software request always counts; a stuck pin is released by selecting any other source
		nxt_state.syncReq = !state_ff.swSyncN;
		case (syncSel)
			SLC_SYNC_DEDICATED: begin
				nxt_state.syncReq = !state_ff.swSyncN || !state_ff.syncPinLevel;
			end
			SLC_SYNC_TIMESTAMP: begin
				nxt_state.syncReq = !state_ff.swSyncN || (timestampReceiverEnable && !state_ff.tsPinLevel);
			end
			default: begin
				nxt_state.syncReq = !state_ff.swSyncN;
			end
		endcase

		nxt_state.twosComp = state_ff.linkControl[SLC_POS_SAMPLE_FORMAT];
		nxt_state.scramble = linkMode8b10b ? state_ff.linkControl[SLC_POS_SCRAMBLER_ENABLE] : 1'b1;
		nxt_state.pattern = slcPatternEffective(state_ff.testControl[4:0], linkMode8b10b);
		nxt_state.patternBad = slcPatternEffective(state_ff.testControl[4:0], linkMode8b10b) != state_ff.testControl[4:0];
		nxt_state.identA = evenIdent;
		nxt_state.identB = evenIdent + 8'h01;
		nxt_state.eofChar = slcCommaChar(state_ff.frameEndChar[1:0]);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff <= SLC_RST_STATE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign wb_dat_o = state_ff.readData;
	assign wb_ack_o = state_ff.ack;
	assign laneEnableA = state_ff.laneA;
	assign laneEnableB = state_ff.laneB;
	assign linkResetHold = state_ff.linkHold;
	assign serializerPowerDown = state_ff.linkHold;
	assign linkClockEnable = !state_ff.linkHold;
	assign syncRequest = state_ff.syncReq;
	assign sampleTwosComplement = state_ff.twosComp;
	assign scrambleActive = state_ff.scramble;
	assign testPatternSelect = state_ff.pattern;
	assign testPatternRejected = state_ff.patternBad;
	assign ilasDeviceIdentA = state_ff.identA;
	assign ilasDeviceIdentB = state_ff.identB;
	assign endOfFrameComma = state_ff.eofChar;

	lanes_lower_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff.linkEnable && !state_ff.linkControl[SLC_POS_UPPER_LANES])
		|=> (laneEnableA == SLC_LANES_LOWER) && (laneEnableB == SLC_LANES_LOWER))
		else $error("lower lane mapping not applied");

	lanes_upper_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff.linkEnable && state_ff.linkControl[SLC_POS_UPPER_LANES])
		|=> (laneEnableA == SLC_LANES_UPPER) && (laneEnableB == SLC_LANES_UPPER))
		else $error("upper lane mapping not applied");

	link_disabled_a: assert property (@(posedge core_clk) disable iff (rst)
		!state_ff.linkEnable |=> linkResetHold && serializerPowerDown && !linkClockEnable && (laneEnableA == SLC_LANES_OFF))
		else $error("disabled link not held off");

	pin_sync_a: assert property (@(posedge core_clk) disable iff (rst)
		(syncSel == SLC_SYNC_DEDICATED && !state_ff.syncPinLevel) |=> syncRequest)
		else $error("dedicated pin sync request missed");

	soft_only_a: assert property (@(posedge core_clk) disable iff (rst)
		(syncSel == SLC_SYNC_SOFTWARE && state_ff.swSyncN) [*2] |-> !syncRequest)
		else $error("pin leaked into software-only sync");

	soft_sync_a: assert property (@(posedge core_clk) disable iff (rst)
		!state_ff.swSyncN |=> syncRequest)
		else $error("software sync request ignored");

	scramble_mode_a: assert property (@(posedge core_clk) disable iff (rst)
		linkMode8b10b |=> scrambleActive == $past(state_ff.linkControl[SLC_POS_SCRAMBLER_ENABLE]))
		else $error("8b/10b scrambling does not follow the bit");

	scramble_force_a: assert property (@(posedge core_clk) disable iff (rst)
		!linkMode8b10b |=> scrambleActive)
		else $error("64b/66b scrambling not forced");

	format_follow_a: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> sampleTwosComplement == $past(state_ff.linkControl[SLC_POS_SAMPLE_FORMAT]))
		else $error("sample format output stale");

	reset_values_a: assert property (@(posedge core_clk)
		$fell(rst) |-> (state_ff.linkControl == SLC_RST_LINK_CONTROL) && (state_ff.testControl == SLC_RST_TEST_CONTROL)
		&& (state_ff.frameEndChar == SLC_RST_FRAME_END_CHAR) && sampleTwosComplement && scrambleActive)
		else $error("register reset values wrong");

	test_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff.testControl[4:0] == SLC_PAT_K28_7 && !linkMode8b10b) |=> testPatternSelect == SLC_PAT_NORMAL && testPatternRejected)
		else $error("8b/10b-only test pattern used in 64b/66b");

	test_reserved_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff.testControl[4:0] == 5'h0C || state_ff.testControl[4:0] > SLC_PAT_K28_7)
		|=> testPatternSelect == SLC_PAT_NORMAL && testPatternRejected)
		else $error("reserved test code not rejected");

	test_pass_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff.testControl[4:0] == SLC_PAT_CLOCK) |=> testPatternSelect == SLC_PAT_CLOCK && !testPatternRejected)
		else $error("clock pattern not selected");

	ident_pair_a: assert property (@(posedge core_clk) disable iff (rst)
		ilasDeviceIdentB == ilasDeviceIdentA + 8'h01 && !ilasDeviceIdentA[0])
		else $error("link identifiers not paired");

	ident_read_a: assert property (@(posedge core_clk) disable iff (rst)
		(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && busIndex == SLC_IDX_DEVICE_IDENT) |=> !wb_dat_o[0])
		else $error("identifier bit zero read as one");

	comma_pick_a: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff.frameEndChar[1:0] == SLC_EOF_K28_5) |=> endOfFrameComma == SLC_CHAR_K28_5)
		else $error("end-of-frame comma not K28.5");

	ack_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held over two cycles");

endmodule

`default_nettype wire

// ---- tb/slc_rx_model.sv ----
// Receiver-side model driving the two active-low sync request pins
`timescale 1ns/1ps
`default_nettype none

module slc_rx_model (
	input wire logic core_clk,
	input wire logic wantSync,
	input wire logic viaTimestamp,
	output logic dedicatedSyncInN,
	output logic timestampInN
);
	// Pins idle high; the receiver always drives them, so no float state
	initial begin
		dedicatedSyncInN = 1'b1;
		timestampInN = 1'b1;
	end
	// Changes land just after an edge, like the receiver's own output flops
	always @(posedge core_clk) begin
		dedicatedSyncInN <= !(wantSync && !viaTimestamp);
		timestampInN <= !(wantSync && viaTimestamp);
	end
endmodule

`default_nettype wire

// ---- tb/slc_tx_config_regs_test.sv ----
// Self-checking bench for the transmit link configuration registers
`timescale 1ns/1ps
`default_nettype none

module slc_tx_config_regs_test;
	import slc_pkg::*;
	typedef struct packed {logic wr; logic [9:0] idx; logic [7:0] d; logic [7:0] exp;} slc_row_type;
	localparam slc_row_type ROWS [0:12] = '{
		'{1'b0, SLC_IDX_LINK_ENABLE, 8'h00, 8'h01},
		'{1'b0, SLC_IDX_SW_SYNC, 8'h00, 8'h01},
		'{1'b0, SLC_IDX_LINK_CONTROL, 8'h00, 8'h03},
		'{1'b0, SLC_IDX_TEST_CONTROL, 8'h00, 8'h00},
		'{1'b0, SLC_IDX_DEVICE_IDENT, 8'h00, 8'h00},
		'{1'b0, SLC_IDX_FRAME_END_CHAR, 8'h00, 8'h00},
		'{1'b1, SLC_IDX_LINK_ENABLE, 8'h00, 8'h00},
		'{1'b1, SLC_IDX_DEVICE_IDENT, 8'h55, 8'h54},
		'{1'b1, SLC_IDX_TEST_CONTROL, 8'hFF, 8'hFF},
		'{1'b1, SLC_IDX_FRAME_END_CHAR, 8'hFE, 8'hFE},
		'{1'b1, SLC_IDX_LINK_CONTROL, 8'hE0, 8'hE0},
		'{1'b1, 10'h201, 8'h5A, 8'h00},
		'{1'b1, SLC_IDX_CFG_STATUS, 8'hFF, 8'h04}
	};
	localparam logic [7:0] LC [0:3] = '{8'h00, 8'h10, 8'h02, 8'h11};
	localparam logic [7:0] EOFC [0:3] = '{8'hFC, 8'h3C, 8'hBC, 8'hFC};
	localparam logic [7:0] IDS [0:2] = '{8'h37, 8'hFF, 8'h10};
	logic core_clk, rst, cyc, stb, we, mode8b, tsEn, wantSync, viaTs, ack, syncN, tsN;
	logic resetHold, serPd, clkEn, syncReq, twos, scrambler_enable, rej;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [3:0] sel;
	logic [7:0] laneA, laneB, idA, idB, eofChar;
	logic [4:0] pat;
	logic ok;
	int n_errors = 0;
	int checked = 0;

	slc_tx_config_regs dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dedicatedSyncInN(syncN), .timestampInN(tsN), .timestampReceiverEnable(tsEn), .linkMode8b10b(mode8b),
		.laneEnableA(laneA), .laneEnableB(laneB), .linkResetHold(resetHold), .serializerPowerDown(serPd),
		.linkClockEnable(clkEn), .syncRequest(syncReq), .sampleTwosComplement(twos), .scrambleActive(scrambler_enable),
		.testPatternSelect(pat), .testPatternRejected(rej), .ilasDeviceIdentA(idA), .ilasDeviceIdentB(idB),
		.endOfFrameComma(eofChar));
	slc_rx_model rx (.core_clk(core_clk), .wantSync(wantSync), .viaTimestamp(viaTs),
		.dedicatedSyncInN(syncN), .timestampInN(tsN));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = !core_clk;
	end

	task end_of_test;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Ack and read data are taken at the rising edge where ack is seen high; release follows at once
	task bus(input logic w, input logic [9:0] i, input logic [7:0] d, input logic [3:0] s);
		bit got;
		got = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h0, d};
		sel <= s;
		for (int k = 0; k < 20 && !got; k++) begin
			@(posedge core_clk);
			if (ack === 1'b1) begin
				got = 1;
				q = rdat;
			end
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		if (!got) begin
			n_errors++;
			end_of_test();
		end
	endtask

	task wr(input logic [9:0] i, input logic [7:0] d);
		bus(1'b1, i, d, 4'hF);
	endtask

	task settle(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	initial begin
		{cyc, stb, we, tsEn, wantSync, viaTs} = '0;
		{adr, wdat, sel} = '0;
		mode8b = 1'b1;
		rst = 1'b1;
		settle(6);
		chk({laneA, laneB, resetHold, serPd, clkEn, twos, scrambler_enable}, {16'h0, 5'b11011});
		chk({idB, eofChar, pat, rej}, {8'h01, SLC_CHAR_K28_7, 6'h0});
		@(posedge core_clk);
		@(posedge core_clk);
		rst <= 1'b0;
		foreach (ROWS[r]) begin
			if (ROWS[r].wr) begin
				wr(ROWS[r].idx, ROWS[r].d);
			end
			bus(1'b0, ROWS[r].idx, 8'h00, 4'hF);
			chk(q, {24'h0, ROWS[r].exp});
		end
		// Settings are only changed with the link disabled, upper mapping assumes an eight-lane mode
		for (int k = 0; k < 4; k++) begin
			wr(SLC_IDX_LINK_ENABLE, 8'h00);
			wr(SLC_IDX_LINK_CONTROL, LC[k]);
			settle(3);
			chk({laneA, laneB, resetHold, serPd, clkEn}, {16'h0, 3'b110});
			wr(SLC_IDX_LINK_ENABLE, 8'h01);
			settle(3);
			chk({laneA, laneB}, LC[k][4] ? 16'hF0F0 : 16'h0F0F);
			chk({twos, scrambler_enable, resetHold, clkEn}, {LC[k][1], LC[k][0], 2'b01});
			@(posedge core_clk);
			mode8b <= 1'b0;
			settle(3);
			chk(scrambler_enable, 1'b1);
			@(posedge core_clk);
			mode8b <= 1'b1;
		end
		wr(SLC_IDX_LINK_ENABLE, 8'h00);
		for (int m = 1; m >= 0; m--) begin
			@(posedge core_clk);
			mode8b <= m[0];
			for (int c = 0; c < 32; c++) begin
				wr(SLC_IDX_TEST_CONTROL, 8'(c) | 8'hE0);
				settle(3);
				ok = !(c == 12 || c > 16) && (m == 1 || !(c inside {7, 8, 9, 16}));
				chk({pat, rej}, ok ? {5'(c), 1'b0} : 6'h01);
			end
		end
		@(posedge core_clk);
		mode8b <= 1'b1;
		foreach (IDS[k]) begin
			wr(SLC_IDX_DEVICE_IDENT, IDS[k]);
			settle(3);
			chk({idA, idB}, {IDS[k] & 8'hFE, (IDS[k] & 8'hFE) + 8'h01});
		end
		bus(1'b1, SLC_IDX_DEVICE_IDENT, 8'h22, 4'hE);
		bus(1'b0, SLC_IDX_DEVICE_IDENT, 8'h00, 4'hF);
		chk(q, 32'h10);
		for (int e = 0; e < 4; e++) begin
			wr(SLC_IDX_FRAME_END_CHAR, 8'hFC | 8'(e));
			settle(3);
			chk(eofChar, EOFC[e]);
		end
		for (int s = 0; s < 4; s++) begin
			wr(SLC_IDX_LINK_CONTROL, {4'h0, 2'(s), 2'b11});
			@(posedge core_clk);
			wantSync <= 1'b1;
			settle(8);
			chk(syncReq, s == 0);
			@(posedge core_clk);
			viaTs <= 1'b1;
			tsEn <= 1'b1;
			settle(8);
			chk(syncReq, s == 1);
			@(posedge core_clk);
			wantSync <= 1'b0;
			viaTs <= 1'b0;
			tsEn <= 1'b0;
			settle(8);
			chk(syncReq, 1'b0);
			wr(SLC_IDX_SW_SYNC, 8'h00);
			settle(3);
			chk(syncReq, 1'b1);
			bus(1'b0, SLC_IDX_CFG_STATUS, 8'h00, 4'hF);
			chk(q[0], 1'b1);
			wr(SLC_IDX_SW_SYNC, 8'h01);
			settle(3);
			chk(syncReq, 1'b0);
		end
		// Second reset in mid-run brings every field back
		@(posedge core_clk);
		rst <= 1'b1;
		settle(3);
		chk({laneA, resetHold, idA, eofChar}, {8'h0, 1'b1, 8'h0, SLC_CHAR_K28_7});
		@(posedge core_clk);
		rst <= 1'b0;
		settle(3);
		chk({laneA, laneB, twos, scrambler_enable}, {16'h0F0F, 2'b11});
		end_of_test();
	end
endmodule

`default_nettype wire
